// File: tb/bod_cmp_model.sv
/*
 * Supply comparator and free-running slow oscillator model.
 * Assumes the bench sets the supply level in millivolts.
 */
`timescale 1ns/10ps
`default_nettype none

module bod_cmp_model (
	input wire logic detectorEnable, // Comparator power
	input wire logic [1:0] thresholdSelect, // Threshold code
	input wire logic [15:0] supplyMv, // Supply level, mV
	output logic slowInternalOsc, // Slow clock, free running
	output logic cmpBelow // High while powered and supply below threshold
);
	logic [15:0] thrMv;
	initial begin
		slowInternalOsc = 1'b0;
		forever #63.7 slowInternalOsc = ~slowInternalOsc;
	end
	always_comb begin
		case (thresholdSelect)
			2'h3: thrMv = 16'h0898;
			2'h2: thrMv = 16'h0A8C;
			2'h1: thrMv = 16'h0E74;
			default: thrMv = 16'h1130;
		endcase
	end
	// Unpowered comparator reports no undervoltage
	assign cmpBelow = detectorEnable && (supplyMv < thrMv);
endmodule // bod_cmp_model

`default_nettype wire

// File: tb/tb_bod_control.sv
/*
 * Self-checking bench for the brown-out control block.
 * Assumes the comparator model above and a 100 MHz clock.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_bod_control
	import bod_pkg::*;
;
	logic clk_sys, rstn, otherReset, sfrPageZero, sfrWr, sfrRd;
	logic timedAccessLock, ie, ge, slowOsc, cmpBelow, den, rstReq, irq;
	logic [7:0] sfrAddr, sfrWdata, sfrRdata, cfg, r;
	logic [1:0] thr;
	logic [15:0] supplyMv;
	logic [31:0] seed;
	int errors, checkCount, resetPulses;

	bod_control dut_u (.clk_sys(clk_sys), .rstn(rstn),
		.otherReset(otherReset), .sfrAddr(sfrAddr),
		.sfrPageZero(sfrPageZero), .sfrWr(sfrWr), .sfrRd(sfrRd),
		.sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
		.timedAccessLock(timedAccessLock), .nvConfigByte(cfg),
		.undervoltIrqEnable(ie), .globalIrqEnable(ge),
		.slowInternalOsc(slowOsc), .cmpBelow(cmpBelow),
		.detectorEnable(den), .thresholdSelect(thr),
		.undervoltResetReq(rstReq), .undervoltIrqReq(irq));
	bod_cmp_model cmp_u (.detectorEnable(den), .thresholdSelect(thr),
		.supplyMv(supplyMv), .slowInternalOsc(slowOsc),
		.cmpBelow(cmpBelow));

	function automatic logic [31:0] nxt_rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [15:0] thr_mv(input logic [1:0] k);
		return (k == 2'h3) ? 16'h0898 : (k == 2'h2) ? 16'h0A8C :
			(k == 2'h1) ? 16'h0E74 : 16'h1130;
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checkCount++;
		if (got !== exp) begin
			errors++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] d, input logic lk,
		input logic [7:0] a, input logic pg);
		@(posedge clk_sys);
		sfrWr <= 1'b1;
		sfrWdata <= d;
		sfrAddr <= a;
		sfrPageZero <= pg;
		timedAccessLock <= lk;
		@(posedge clk_sys);
		sfrWr <= 1'b0;
		timedAccessLock <= 1'b0;
		#1;
	endtask
	task automatic rd();
		@(posedge clk_sys);
		sfrRd <= 1'b1;
		sfrAddr <= BOD_CTRL_ADDR;
		sfrPageZero <= 1'b1;
		@(posedge clk_sys);
		sfrRd <= 1'b0;
		#1 r = sfrRdata;
	endtask
	task automatic test_done();
		$display("errors=%0d checks=%0d", errors, checkCount);
		if (errors == 0 && checkCount > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	always @(posedge clk_sys) if (rstReq === 1'b1) resetPulses++;

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		#400000;
		errors++;
		test_done();
	end

	initial begin
		seed = 32'h0000BDCC;
		rstn = 1'b0;
		{otherReset, sfrPageZero, sfrWr, sfrRd, timedAccessLock} = 5'h00;
		{ie, ge, sfrAddr, sfrWdata} = 18'h00000;
		supplyMv = 16'h1388;
		cfg = 8'(nxt_rnd());
		repeat (16) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rd();
		chk(r, {cfg[7], 1'b0, cfg[5:4], 1'b0, cfg[2], 2'h0});
		// Locked, wrong address and wrong page writes are dropped
		wr(8'hFF, 1'b0, BOD_CTRL_ADDR, 1'b1);
		wr(8'hFF, 1'b1, 8'hA4, 1'b1);
		wr(8'hFF, 1'b1, BOD_CTRL_ADDR, 1'b0);
		rd();
		chk(r, {cfg[7], 1'b0, cfg[5:4], 1'b0, cfg[2], 2'h0});
		resetPulses = 0;
		for (int k = 0; k < 4; k++) begin
			wr(8'h00, 1'b1, BOD_CTRL_ADDR, 1'b1);
			supplyMv = thr_mv(k[1:0]) - 16'd100 - 16'(nxt_rnd() % 400);
			repeat (10) @(posedge clk_sys);
			rd();
			chk(r, 8'h00);
			wr({2'h3, k[1:0], 4'h1}, 1'b1, BOD_CTRL_ADDR, 1'b1);
			chk({den, 5'h00, thr}, {1'b1, 5'h00, k[1:0]});
			rd();
			chk(r & 8'h01, 8'h00);
			repeat (80) @(posedge clk_sys);
			rd();
			chk(r & 8'hF5, {2'h2, k[1:0], 4'h1});
			wr({2'h2, k[1:0], 4'h0}, 1'b1, BOD_CTRL_ADDR, 1'b1);
			supplyMv = thr_mv(k[1:0]) + 16'd100 + 16'(nxt_rnd() % 400);
			repeat (20) @(posedge clk_sys);
			rd();
			chk(r, {2'h2, k[1:0], 4'h8});
			for (int m = 0; m < 4; m++) begin
				@(posedge clk_sys);
				{ie, ge} <= m[1:0];
				repeat (3) @(posedge clk_sys);
				#1 chk({7'h00, irq}, {7'h00, m == 3});
			end
			wr({2'h2, k[1:0], 4'h0}, 1'b1, BOD_CTRL_ADDR, 1'b1);
			rd();
			chk(r, {2'h2, k[1:0], 4'h0});
			chk({7'h00, irq}, 8'h00);
			supplyMv = thr_mv(k[1:0]) - 16'd200;
			repeat (20) @(posedge clk_sys);
			rd();
			chk(r, {2'h2, k[1:0], 4'h9});
		end
		chk(resetPulses[7:0], 8'h00);
		wr(8'hB4, 1'b1, BOD_CTRL_ADDR, 1'b1);
		repeat (100) @(posedge clk_sys);
		supplyMv = 16'h1388;
		repeat (100) @(posedge clk_sys);
		chk({7'h00, resetPulses > 0}, 8'h01);
		rd();
		chk(r & 8'hF7, {cfg[7], 1'b0, cfg[5:4], 1'b0, cfg[2], 2'h2});
		@(posedge clk_sys);
		otherReset <= 1'b1;
		@(posedge clk_sys);
		otherReset <= 1'b0;
		rd();
		chk(r & 8'h02, 8'h02);
		// Software clears the cause after reading it, then sets it again
		wr(8'h00, 1'b1, BOD_CTRL_ADDR, 1'b1);
		rd();
		chk(r & 8'h02, 8'h00);
		wr(8'h02, 1'b1, BOD_CTRL_ADDR, 1'b1);
		rd();
		chk(r & 8'h02, 8'h02);
		@(posedge clk_sys);
		rstn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rd();
		chk(r & 8'h02, 8'h00);
		test_done();
	end
endmodule // tb_bod_control

`default_nettype wire

// File: verilog/bod_control.sv
/*
 * Brown-out detector control and status register with settling,
 * crossing flag, reset request and interrupt request.
 * Assumes an 8-bit SFR bus on clk_sys, a timed-access unlock level from
 * the SFR unit, and an asynchronous comparator and slow oscillator.
 */
// Contract
// - enable bit switches detector off or on
// - output invalid for 2-3 slow clocks
// - two-bit code selects one of four thresholds
// - either supply crossing sets interrupt flag
// - interrupt needs flag, enable, global enable
// - reset enable gates brown-out system reset
// - brown-out reset sets reset cause flag
// - status reads 0 when disabled or high
// - enabled and supply low gives status 1
// - status bit is read-only
// - every reset reloads fields from config byte
// - flag reset value from config and supply
// - writes accepted only while timed access open
`timescale 1ns/10ps
`default_nettype none

module bod_control
	import bod_pkg::*;
(
	input wire logic clk_sys, // System clock, 100 MHz
	input wire logic rstn, // Power-on reset, asynchronous, active low
	input wire logic otherReset, // Any non-power-on system reset, level
	input wire logic [7:0] sfrAddr, // SFR address
	input wire logic sfrPageZero, // SFR page 0 selected
	input wire logic sfrWr, // SFR write strobe
	input wire logic sfrRd, // SFR read strobe
	input wire logic [7:0] sfrWdata, // SFR write data
	output logic [7:0] sfrRdata, // SFR read data, one cycle after strobe
	input wire logic timedAccessLock, // High while unlock window is open
	input wire logic [7:0] nvConfigByte, // Non-volatile configuration byte
	input wire logic undervoltIrqEnable, // Brown-out interrupt enable
	input wire logic globalIrqEnable, // Global interrupt enable
	input wire logic slowInternalOsc, // Slow oscillator, asynchronous
	input wire logic cmpBelow, // Comparator: supply below threshold
	output logic detectorEnable, // Powers the comparator
	output logic [1:0] thresholdSelect, // Threshold code to comparator
	output logic undervoltResetReq, // System reset request
	output logic undervoltIrqReq // Interrupt request
);

	typedef enum logic [1:0] {S_OFF, S_SETTLE, S_ON} bod_phase_e;

	typedef struct packed {
		bod_phase_e phase;
		logic [1:0] settleCnt;
		logic loaded;
		logic detEn;
		logic [1:0] thr;
		logic irqFlag;
		logic rstEn;
		logic resetCause;
		logic lowStatus;
		logic oscPrev;
		logic cmpPrev;
		logic rstReq;
		logic irqReq;
		logic [7:0] rdData;
	} bod_state_s;

	bod_state_s s_r;
	bod_state_s s_nxt;
	logic cmpLow;
	logic oscLevel;
	logic oscEdge;
	logic valid;
	logic crossing;
	logic trip;
	logic hit;
	logic wrHit;
	logic reload;

	bod_sync_if syncLink();

	// ****************************************
	// Input synchronisation
	// ****************************************
	assign syncLink.raw = {slowInternalOsc, cmpBelow};

	bod_sync u_sync (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.link(syncLink)
	);

	assign cmpLow = syncLink.stable[0];
	assign oscLevel = syncLink.stable[1];
	assign oscEdge = oscLevel & ~s_r.oscPrev;
	assign valid = (s_r.phase == S_ON);
	assign crossing = valid && (cmpLow != s_r.cmpPrev);
	assign trip = valid && s_r.rstEn && cmpLow;
	assign hit = sfrPageZero && (sfrAddr == BOD_CTRL_ADDR);
	assign wrHit = sfrWr && hit && timedAccessLock;
	assign reload = otherReset || trip || !s_r.loaded;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		s_nxt = s_r;
		s_nxt.oscPrev = oscLevel;
		s_nxt.cmpPrev = cmpLow;
		if (wrHit) begin
			s_nxt.detEn = sfrWdata[BOD_EN_BIT];
			s_nxt.thr = sfrWdata[BOD_THR_HI:BOD_THR_LO];
			s_nxt.irqFlag = sfrWdata[BOD_FLAG_BIT];
			s_nxt.rstEn = sfrWdata[BOD_RSTEN_BIT];
			s_nxt.resetCause = sfrWdata[BOD_CAUSE_BIT];
		end
		// Hardware set after software write, so the set wins
		if (crossing) begin
			s_nxt.irqFlag = 1'b1;
		end
		if (reload) begin
			s_nxt.detEn = nvConfigByte[BOD_EN_BIT];
			s_nxt.thr = nvConfigByte[BOD_THR_HI:BOD_THR_LO];
			s_nxt.rstEn = nvConfigByte[BOD_RSTEN_BIT];
			s_nxt.irqFlag = nvConfigByte[BOD_EN_BIT] & cmpLow;
			s_nxt.loaded = 1'b1;
			if (trip) begin
				s_nxt.resetCause = BOD_TRIP_CAUSE;
			end
		end
		if (!s_nxt.detEn || reload) begin
			s_nxt.phase = S_OFF;
			s_nxt.settleCnt = '0;
		end else begin
			unique case (s_r.phase)
				S_OFF: begin
					s_nxt.phase = S_SETTLE;
					s_nxt.settleCnt = '0;
				end
				S_SETTLE: begin
					if (oscEdge) begin
						s_nxt.settleCnt = s_r.settleCnt + 2'h1;
						if (s_r.settleCnt == BOD_SETTLE_EDGES - 2'h1) begin
							s_nxt.phase = S_ON;
						end
					end
				end
				S_ON: begin
					s_nxt.phase = S_ON;
				end
			endcase
		end
		s_nxt.lowStatus = valid && s_nxt.detEn && cmpLow;
		s_nxt.rstReq = trip;
		s_nxt.irqReq = s_nxt.irqFlag && undervoltIrqEnable &&
			globalIrqEnable;
		s_nxt.rdData = BOD_READ_IDLE;
		if (sfrRd && hit) begin
			s_nxt.rdData[BOD_EN_BIT] = s_r.detEn;
			s_nxt.rdData[BOD_THR_HI:BOD_THR_LO] = s_r.thr;
			s_nxt.rdData[BOD_FLAG_BIT] = s_r.irqFlag;
			s_nxt.rdData[BOD_RSTEN_BIT] = s_r.rstEn;
			s_nxt.rdData[BOD_CAUSE_BIT] = s_r.resetCause;
			s_nxt.rdData[BOD_STATUS_BIT] = s_r.lowStatus;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s_r <= '0;
			s_r.phase <= S_OFF;
			s_r.resetCause <= BOD_POR_CAUSE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign sfrRdata = s_r.rdData;
	assign detectorEnable = s_r.detEn;
	assign thresholdSelect = s_r.thr;
	assign undervoltResetReq = s_r.rstReq;
	assign undervoltIrqReq = s_r.irqReq;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);

	a_locked_write: assert property (
		(sfrWr && hit && !timedAccessLock && !reload) |=>
			detectorEnable == $past(detectorEnable))
		else $error("write accepted while timed access closed");

	a_enable_write: assert property (
		(wrHit && !reload) |=> detectorEnable == $past(sfrWdata[BOD_EN_BIT]))
		else $error("enable bit did not follow write");

	a_settle_edges: assert property (
		(s_r.phase == S_SETTLE && s_nxt.phase == S_ON) |->
			(oscEdge && s_r.settleCnt == BOD_SETTLE_EDGES - 2'h1))
		else $error("detector valid before settling edges");

	a_cfg_reload: assert property (
		(otherReset && s_r.loaded) |=>
			thresholdSelect == $past(nvConfigByte[BOD_THR_HI:BOD_THR_LO]))
		else $error("threshold not reloaded from config");

	a_crossing_flag: assert property (
		(crossing && !reload) |=> s_r.irqFlag)
		else $error("crossing did not set flag");

	a_irq_gate: assert property (
		undervoltIrqReq |-> $past(undervoltIrqEnable && globalIrqEnable))
		else $error("interrupt without enables");

	a_reset_gate: assert property (
		undervoltResetReq |-> $past(s_r.rstEn && valid && cmpLow))
		else $error("reset request without cause");

	a_cause_set: assert property (
		undervoltResetReq |-> s_r.resetCause)
		else $error("reset cause not set");

	a_status_off: assert property (
		!valid |=> !s_r.lowStatus)
		else $error("status high while detector not valid");

	a_status_low: assert property (
		(valid && s_nxt.detEn && cmpLow) |=> s_r.lowStatus)
		else $error("status not raised for low supply");

	c_crossing: cover property (crossing);
	c_trip: cover property (trip ##1 undervoltResetReq);
	c_write: cover property (wrHit ##1 detectorEnable);
	c_low_thr: cover property (valid && thresholdSelect == BOD_THR_2V2);

endmodule // bod_control

`default_nettype wire

// File: verilog/bod_pkg.sv
/*
 * Constants for the supply brown-out detector control block: the SFR
 * address, the field layout of the control register, reset values and the
 * settling count. Assumes an 8-bit SFR bus and one system clock.
 */
`default_nettype none

package bod_pkg;

	// ****************************************
	// Register address; page 0 is selected by sfrPageZero
	// ****************************************
	localparam logic [7:0] BOD_CTRL_ADDR = 8'hA3;

	// ****************************************
	// Field positions, shared by register and configuration byte
	// ****************************************
	localparam int BOD_EN_BIT = 7;
	localparam int BOD_THR_HI = 5;
	localparam int BOD_THR_LO = 4;
	localparam int BOD_FLAG_BIT = 3;
	localparam int BOD_RSTEN_BIT = 2;
	localparam int BOD_CAUSE_BIT = 1;
	localparam int BOD_STATUS_BIT = 0;

	// ****************************************
	// Threshold codes
	// ****************************************
	localparam logic [1:0] BOD_THR_2V2 = 2'h3;
	localparam logic [1:0] BOD_THR_2V7 = 2'h2;
	localparam logic [1:0] BOD_THR_3V7 = 2'h1;
	localparam logic [1:0] BOD_THR_4V4 = 2'h0;

	// ****************************************
	// Reset values and timing
	// ****************************************
	localparam logic BOD_POR_CAUSE = 1'h0;
	localparam logic BOD_TRIP_CAUSE = 1'h1;
	localparam logic [7:0] BOD_READ_IDLE = 8'h00;
	// Slow-oscillator edges after enable before the output counts as valid
	localparam logic [1:0] BOD_SETTLE_EDGES = 2'h3;
	localparam int BOD_SYNC_BITS = 2;

endpackage

`default_nettype wire

// File: verilog/bod_sync.sv
/*
 * Three-stage synchroniser for asynchronous inputs; a change is taken once
 * the second and third stages agree. Assumes clk_sys and rstn.
 */
`timescale 1ns/10ps
`default_nettype none

module bod_sync
	import bod_pkg::*;
(
	input wire logic clk_sys, // System clock
	input wire logic rstn, // Asynchronous reset, active low
	bod_sync_if.sync link // Raw in, filtered out
);

	typedef struct packed {
		logic [BOD_SYNC_BITS-1:0] ff1;
		logic [BOD_SYNC_BITS-1:0] ff2;
		logic [BOD_SYNC_BITS-1:0] ff3;
		logic [BOD_SYNC_BITS-1:0] stable;
	} bod_sync_s;

	bod_sync_s s_r;
	bod_sync_s s_nxt;
	logic [BOD_SYNC_BITS-1:0] agreed;

	// ****************************************
	// Per-bit agreement filter
	// ****************************************
	genvar i;
	generate
		for (i = 0; i < BOD_SYNC_BITS; i++) begin : g_bit
			assign agreed[i] = (s_r.ff2[i] == s_r.ff3[i]) ? s_r.ff3[i] :
				s_r.stable[i];
		end
	endgenerate

	always_comb begin
		s_nxt = s_r;
		s_nxt.ff1 = link.raw;
		s_nxt.ff2 = s_r.ff1;
		s_nxt.ff3 = s_r.ff2;
		s_nxt.stable = agreed;
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign link.stable = s_r.stable;

endmodule // bod_sync

`default_nettype wire

// File: verilog/bod_sync_if.sv
/*
 * Carrier between the control block and its input synchroniser.
 * Assumes both ends run on clk_sys.
 */
`timescale 1ns/10ps
`default_nettype none

interface bod_sync_if;
	import bod_pkg::*;
	logic [BOD_SYNC_BITS-1:0] raw;
	logic [BOD_SYNC_BITS-1:0] stable;
	modport ctrl (output raw, input stable);
	modport sync (input raw, output stable);
endinterface

`default_nettype wire
